// [common/flbp_pkg.sv]
// Shared constants and types for the parallel flash bus host.
package flbp_pkg;

    // Clock period and timing figures, each in nanoseconds.
    localparam int unsigned CLK_NS      = 10;
    localparam int unsigned T_WE_NS     = 50;
    localparam int unsigned T_ACC_NS    = 80;
    localparam int unsigned T_PROT_NS   = 100000;
    localparam int unsigned T_UNPROT_NS = 10000000;
    localparam int unsigned T_RST_NS    = 500;

    // Least times round up to whole clock cycles.
    localparam int unsigned WE_CYC     = (T_WE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PROT_CYC   = (T_PROT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned UNPROT_CYC = (T_UNPROT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RST_CYC    = (T_RST_NS + CLK_NS - 1) / CLK_NS;

    // Data pins pass two flip-flops before a read samples them.
    localparam int unsigned SYNC_STAGES = 2;

    // Widths and address bit positions.
    localparam int unsigned CNT_W   = 24;
    localparam int unsigned ADDR_W  = 17;
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned A_SEL0  = 0;
    localparam int unsigned A_SEL1  = 1;
    localparam int unsigned A_SEL6  = 6;
    localparam int unsigned A_BLK12 = 12;
    localparam int unsigned A_BLK15 = 15;
    localparam int unsigned DQ_TOP  = 15;

    // Bus operations the host can run.
    typedef enum logic [2:0] {
        OP_READ   = 3'h0,
        OP_WRITE  = 3'h1,
        OP_SIG    = 3'h2,
        OP_PROT   = 3'h3,
        OP_UNPROT = 3'h4,
        OP_PVFY   = 3'h5,
        OP_UVFY   = 3'h6,
        OP_RESET  = 3'h7
    } flbp_op_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_SETUP = 2'h1,
        ST_ACT   = 2'h2,
        ST_REC   = 2'h3
    } flbp_state_t;

endpackage

// [logic/flbp_host.sv]
// Host sequencer that drives a parallel flash through its bus pins.
// Notes on behaviour
// - Read data only with select and gate low.
// - Write: select low, strobe low, gate high.
// - Elevated bit 9, bit 1 low: identification.
// - Protect: bit 9 and gate elevated, block address.
// - Protect strobe low about a hundred microseconds.
// - Protect every block before whole unprotection.
// - Unprotect: bit 9, gate, select elevated.
// - Unprotect runs a fixed long delay.
// - Verify unprotection one block at a time.
// - Reset pin low a minimum pulse resets.
`timescale 1ns/1ps
module flbp_host
    import flbp_pkg::*;
#(
    parameter int unsigned PROT_CYCLES   = PROT_CYC,
    parameter int unsigned UNPROT_CYCLES = UNPROT_CYC
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // User command port.
    input  wire logic              cmd_valid,
    input  wire logic [2:0]        cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic              cmd_addr_m1,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    input  wire logic              word_mode,
    input  wire logic              temp_unprot,
    output logic                   cmd_ready,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    // Flash control pins; each _hv output asks for the elevated level.
    output logic                   fl_ce_n,
    output logic                   fl_ce_hv,
    output logic                   fl_oe_n,
    output logic                   fl_oe_hv,
    output logic                   fl_we_n,
    output logic                   fl_rp_n,
    output logic                   fl_rp_hv,
    output logic                   fl_word_sel,
    output logic                   fl_a9_hv,
    output logic [ADDR_W-1:0]      fl_addr,
    // Flash data pins, split into input, output and low-active enable.
    input  wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0]      dq_o,
    output logic [DATA_W-1:0]      dq_oe_n
);

    flbp_state_t       state_ff, nxt_state;
    flbp_op_t          op_ff, nxt_op;
    logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
    logic              word_ff, nxt_word;
    logic              ready_ff, nxt_ready;
    logic              done_ff, nxt_done;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic              ce_n_ff, nxt_ce_n;
    logic              ce_hv_ff, nxt_ce_hv;
    logic              oe_n_ff, nxt_oe_n;
    logic              oe_hv_ff, nxt_oe_hv;
    logic              we_n_ff, nxt_we_n;
    logic              rp_n_ff, nxt_rp_n;
    logic              rp_hv_ff, nxt_rp_hv;
    logic              a9_hv_ff, nxt_a9_hv;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] dq_o_ff, nxt_dq_o;
    logic [DATA_W-1:0] dq_oe_n_ff, nxt_dq_oe_n;
    logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;
    logic              is_read;
    logic              is_strobe;

    // Operations that sample the data bus, and those that pulse the strobe.
    assign is_read   = (op_ff == OP_READ) || (op_ff == OP_SIG) ||
                       (op_ff == OP_PVFY) || (op_ff == OP_UVFY);
    assign is_strobe = (op_ff == OP_WRITE) || (op_ff == OP_PROT) ||
                       (op_ff == OP_UNPROT);

    // Sequencer: set up pin levels, run one timed phase, then release.
    always_comb begin
        nxt_state   = state_ff;
        nxt_op      = op_ff;
        nxt_cnt     = cnt_ff;
        nxt_word    = word_ff;
        nxt_ready   = ready_ff;
        nxt_done    = 1'b0;
        nxt_rdata   = rdata_ff;
        nxt_ce_n    = ce_n_ff;
        nxt_ce_hv   = ce_hv_ff;
        nxt_oe_n    = oe_n_ff;
        nxt_oe_hv   = oe_hv_ff;
        nxt_we_n    = we_n_ff;
        nxt_rp_n    = rp_n_ff;
        nxt_a9_hv   = a9_hv_ff;
        nxt_addr    = addr_ff;
        nxt_dq_o    = dq_o_ff;
        nxt_dq_oe_n = dq_oe_n_ff;
        // The elevated reset level is held only while not pulsing reset.
        nxt_rp_hv   = temp_unprot && rp_n_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (cmd_valid) begin
                    nxt_op    = flbp_op_t'(cmd_op);
                    nxt_word  = word_mode;
                    nxt_ready = 1'b0;
                    nxt_addr  = cmd_addr;
                    nxt_state = ST_SETUP;
                    // Byte mode turns the top data line into an address.
                    if (!word_mode) begin
                        nxt_dq_o[DQ_TOP]    = cmd_addr_m1;
                        nxt_dq_oe_n[DQ_TOP] = 1'b0;
                    end
                    unique case (flbp_op_t'(cmd_op))
                        OP_READ: begin
                            nxt_ce_n = 1'b0;
                        end
                        OP_WRITE: begin
                            nxt_ce_n = 1'b0;
                            nxt_dq_o[BYTE_W-1:0]    = cmd_wdata[BYTE_W-1:0];
                            nxt_dq_oe_n[BYTE_W-1:0] = '0;
                            if (word_mode) begin
                                nxt_dq_o    = cmd_wdata;
                                nxt_dq_oe_n = '0;
                            end
                        end
                        OP_SIG: begin
                            nxt_ce_n         = 1'b0;
                            nxt_a9_hv        = 1'b1;
                            nxt_addr[A_SEL1] = 1'b0;
                        end
                        OP_PROT: begin
                            nxt_ce_n  = 1'b0;
                            nxt_oe_hv = 1'b1;
                            nxt_a9_hv = 1'b1;
                        end
                        OP_UNPROT: begin
                            nxt_ce_hv         = 1'b1;
                            nxt_oe_hv         = 1'b1;
                            nxt_a9_hv         = 1'b1;
                            nxt_addr[A_BLK12] = 1'b1;
                            nxt_addr[A_BLK15] = 1'b1;
                        end
                        OP_PVFY, OP_UVFY: begin
                            nxt_ce_n         = 1'b0;
                            nxt_a9_hv        = 1'b1;
                            nxt_addr[A_SEL0] = 1'b0;
                            nxt_addr[A_SEL1] = 1'b1;
                            nxt_addr[A_SEL6] = (cmd_op == OP_UVFY);
                        end
                        OP_RESET: begin
                            nxt_ce_n = 1'b1;
                        end
                    endcase
                end
            end
            ST_SETUP: begin
                nxt_state = ST_ACT;
                if (is_read) begin
                    // Gate goes low only after the data drivers are off.
                    nxt_oe_n = 1'b0;
                    nxt_cnt  = CNT_W'(ACC_CYC + SYNC_STAGES - 1);
                end else if (op_ff == OP_RESET) begin
                    nxt_rp_n  = 1'b0;
                    nxt_rp_hv = 1'b0;
                    nxt_cnt   = CNT_W'(RST_CYC - 1);
                end else begin
                    // Strobe falls after select, so it sets the address edge.
                    nxt_we_n = 1'b0;
                    if (op_ff == OP_PROT) begin
                        nxt_cnt = CNT_W'(PROT_CYCLES - 1);
                    end else if (op_ff == OP_UNPROT) begin
                        nxt_cnt = CNT_W'(UNPROT_CYCLES - 1);
                    end else begin
                        nxt_cnt = CNT_W'(WE_CYC - 1);
                    end
                end
            end
            ST_ACT: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end else begin
                    nxt_state = ST_REC;
                    nxt_oe_n  = 1'b1;
                    nxt_rp_n  = 1'b1;
                    // Strobe rises before select, so it sets the data edge.
                    nxt_we_n  = 1'b1;
                    if (is_read) begin
                        nxt_rdata = word_ff ? dq_s2_ff
                                  : {{BYTE_W{1'b0}}, dq_s2_ff[BYTE_W-1:0]};
                    end
                end
            end
            ST_REC: begin
                // Deselect returns the device to standby with outputs off.
                nxt_ce_n    = 1'b1;
                nxt_ce_hv   = 1'b0;
                nxt_oe_hv   = 1'b0;
                nxt_a9_hv   = 1'b0;
                nxt_dq_oe_n = '1;
                nxt_done    = 1'b1;
                nxt_ready   = 1'b1;
                nxt_state   = ST_IDLE;
            end
        endcase
    end

    // Registers of the sequencer and of every pin it drives.
    always_ff @(posedge clk) begin
        dq_s1_ff <= dq_i;
        dq_s2_ff <= dq_s1_ff;
        if (rst) begin
            state_ff   <= ST_IDLE;
            op_ff      <= OP_READ;
            cnt_ff     <= '0;
            word_ff    <= 1'b1;
            ready_ff   <= 1'b1;
            done_ff    <= 1'b0;
            rdata_ff   <= '0;
            ce_n_ff    <= 1'b1;
            ce_hv_ff   <= 1'b0;
            oe_n_ff    <= 1'b1;
            oe_hv_ff   <= 1'b0;
            we_n_ff    <= 1'b1;
            rp_n_ff    <= 1'b1;
            rp_hv_ff   <= 1'b0;
            a9_hv_ff   <= 1'b0;
            addr_ff    <= '0;
            dq_o_ff    <= '0;
            dq_oe_n_ff <= '1;
        end else begin
            state_ff   <= nxt_state;
            op_ff      <= nxt_op;
            cnt_ff     <= nxt_cnt;
            word_ff    <= nxt_word;
            ready_ff   <= nxt_ready;
            done_ff    <= nxt_done;
            rdata_ff   <= nxt_rdata;
            ce_n_ff    <= nxt_ce_n;
            ce_hv_ff   <= nxt_ce_hv;
            oe_n_ff    <= nxt_oe_n;
            oe_hv_ff   <= nxt_oe_hv;
            we_n_ff    <= nxt_we_n;
            rp_n_ff    <= nxt_rp_n;
            rp_hv_ff   <= nxt_rp_hv;
            a9_hv_ff   <= nxt_a9_hv;
            addr_ff    <= nxt_addr;
            dq_o_ff    <= nxt_dq_o;
            dq_oe_n_ff <= nxt_dq_oe_n;
        end
    end

    // Outputs come straight from registers.
    assign cmd_ready   = ready_ff;
    assign done        = done_ff;
    assign rdata       = rdata_ff;
    assign fl_ce_n     = ce_n_ff;
    assign fl_ce_hv    = ce_hv_ff;
    assign fl_oe_n     = oe_n_ff;
    assign fl_oe_hv    = oe_hv_ff;
    assign fl_we_n     = we_n_ff;
    assign fl_rp_n     = rp_n_ff;
    assign fl_rp_hv    = rp_hv_ff;
    assign fl_word_sel = word_ff;
    assign fl_a9_hv    = a9_hv_ff;
    assign fl_addr     = addr_ff;
    assign dq_o        = dq_o_ff;
    assign dq_oe_n     = dq_oe_n_ff;

endmodule

// [verif/flbp_flash_model.sv]
// Behavioural model of the flash memory on the far side of the host.
`timescale 1ns/1ps
module flbp_flash_model
    import flbp_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value.
    parameter logic [7:0] PART_CODE  = 8'h5e  // Arbitrary value.
) (
    // Clock for the read data path.
    input wire logic              clk,
    // Pins; each _hv input is the separate elevated level.
    input wire logic              fl_ce_n,
    input wire logic              fl_ce_hv,
    input wire logic              fl_oe_n,
    input wire logic              fl_oe_hv,
    input wire logic              fl_we_n,
    input wire logic              fl_rp_n,
    input wire logic              fl_rp_hv,
    input wire logic              fl_word_sel,
    input wire logic              fl_a9_hv,
    input wire logic [ADDR_W-1:0] fl_addr,
    input wire logic [DATA_W-1:0] dq_i,
    // Data driven by the memory and its per-bit drive enable.
    output logic     [DATA_W-1:0] dev_dq,
    output logic     [DATA_W-1:0] dev_oe
);
    logic [15:0] mem [logic [17:0]];
    logic [31:0] prot = '0;
    logic [17:0] lat_a;
    logic [17:0] key;
    logic [4:0]  blk;
    logic        rd;

    assign key = {fl_addr, fl_word_sel ? 1'b0 : dq_i[DQ_TOP]};
    assign blk = fl_addr[16:12];
    assign rd = fl_rp_n && !fl_ce_n && !fl_ce_hv && !fl_oe_n && !fl_oe_hv
        && fl_we_n;
    // Pseudo-standby saves power and leaves the outputs off the bus.
    assign dev_oe = !rd ? 16'h0000
        : fl_word_sel ? 16'hffff : 16'h00ff;

    // Address is taken when the strobe falls, after select.
    always @(negedge fl_we_n) lat_a = key;

    // Strobe rise ends protect, unprotect or a write; others change nothing.
    always @(posedge fl_we_n) begin
        if (!fl_rp_n) begin
        end else if (fl_ce_hv && fl_oe_hv && fl_a9_hv && fl_addr[12]
                     && fl_addr[15]) begin
            prot = '0;
        end else if (fl_oe_hv && fl_a9_hv && !fl_ce_n) begin
            prot[blk] = 1'b1;
        end else if (!fl_ce_n && fl_oe_n && !fl_oe_hv && !fl_a9_hv
                     && (!prot[lat_a[17:13]] || fl_rp_hv)) begin
            mem[lat_a] = fl_word_sel ? dq_i
                : {8'h00, dq_i[7:0]};
        end
    end

    // Read data, a code or protection status; slow sensing by one cycle.
    always @(posedge clk) begin
        if (!fl_a9_hv)
            dev_dq <= mem.exists(key) ? mem[key] : 16'hffff;
        else if (!fl_addr[1])
            dev_dq <= {8'h00, fl_addr[0] ? PART_CODE : MAKER_CODE};
        else
            dev_dq <= {15'h0000, prot[blk]};
    end
endmodule

// [verif/flbp_host_chk.sv]
// Concurrent checks on the pins of the parallel flash bus host.
`timescale 1ns/1ps
module flbp_host_chk
    import flbp_pkg::*;
#(
    parameter int unsigned PROT_CYCLES   = PROT_CYC,
    parameter int unsigned UNPROT_CYCLES = UNPROT_CYC
) (
    // Clock and reset.
    input wire logic              clk,
    input wire logic              rst,
    // Flash pins.
    input wire logic              fl_ce_n,
    input wire logic              fl_ce_hv,
    input wire logic              fl_oe_n,
    input wire logic              fl_oe_hv,
    input wire logic              fl_we_n,
    input wire logic              fl_rp_n,
    input wire logic              fl_rp_hv,
    input wire logic              fl_word_sel,
    input wire logic              fl_a9_hv,
    input wire logic [ADDR_W-1:0] fl_addr,
    input wire logic [DATA_W-1:0] dq_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic [CNT_W-1:0] wlow_ff;
    logic [CNT_W-1:0] nxt_wlow;

    // Counts strobe-low cycles so pulse widths can be judged at the rise.
    always_comb begin
        nxt_wlow = fl_we_n ? '0 : wlow_ff + 1'b1;
    end

    // Registers the strobe counter.
    always_ff @(posedge clk) begin
        wlow_ff <= rst ? '0 : nxt_wlow;
    end

    // In byte mode the top data line carries the low address, even in reads.
    a_write_gate: assert property ($fell(fl_we_n) && !fl_oe_hv |->
        !fl_ce_n && fl_oe_n) else $error("write strobe without select");
    a_read_float: assert property (!fl_oe_n |-> fl_we_n &&
        (&dq_oe_n[DQ_TOP-1:0]) && (dq_oe_n[DQ_TOP] || !fl_word_sel))
        else $error("host drives data during a read");
    a_write_drive: assert property (!fl_we_n && !fl_oe_hv |->
        dq_oe_n[7:0] == 8'h00) else $error("write data not driven");
    a_strobe_width: assert property ($rose(fl_we_n) |->
        wlow_ff == CNT_W'(fl_oe_hv ?
        (fl_ce_hv ? UNPROT_CYCLES : PROT_CYCLES) : WE_CYC))
        else $error("strobe low width wrong");
    a_prot_pins: assert property ($fell(fl_we_n) && fl_oe_hv &&
        !fl_ce_hv |-> fl_a9_hv && !fl_ce_n && fl_rp_n)
        else $error("protect pin levels wrong");
    a_unprot_pins: assert property ($fell(fl_we_n) && fl_ce_hv |->
        fl_oe_hv && fl_a9_hv && fl_addr[A_BLK12] && fl_addr[A_BLK15])
        else $error("unprotect pin levels wrong");
    a_verify_addr: assert property (!fl_oe_n && fl_a9_hv &&
        fl_addr[A_SEL1] |-> !fl_addr[A_SEL0])
        else $error("verify address bit 0 high");
    a_reset_pulse: assert property ($fell(fl_rp_n) |-> !fl_rp_hv
        ##49 !fl_rp_n ##1 fl_rp_n) else $error("reset pulse width wrong");
    a_byte_addr: assert property (!fl_word_sel && !fl_ce_n |->
        !dq_oe_n[DQ_TOP]) else $error("low address line not driven");
endmodule

bind flbp_host flbp_host_chk #(
    .PROT_CYCLES   (PROT_CYCLES),
    .UNPROT_CYCLES (UNPROT_CYCLES)
) u_chk (.clk, .rst, .fl_ce_n, .fl_ce_hv, .fl_oe_n, .fl_oe_hv, .fl_we_n,
    .fl_rp_n, .fl_rp_hv, .fl_word_sel, .fl_a9_hv, .fl_addr, .dq_oe_n);

// [verif/flbp_host_tb.sv]
// Self-checking testbench for the parallel flash bus host.
`timescale 1ns/1ps
module flbp_host_tb;
    import flbp_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value.
    localparam logic [7:0] PART  = 8'h5e; // Arbitrary value.
    logic        clk = 0, rst = 1, cmd_valid = 0, cmd_addr_m1 = 0;
    logic        word_mode = 1, temp_unprot = 0;
    logic [2:0]  cmd_op = 0;
    logic [16:0] cmd_addr = 0, fl_addr;
    logic [15:0] cmd_wdata = 0, rdata, dq_i, dq_o, dq_oe_n, dev_dq, dev_oe;
    logic [15:0] flt = 16'h5a5a;
    logic cmd_ready, done, fl_ce_n, fl_ce_hv, fl_oe_n, fl_oe_hv, fl_we_n;
    logic fl_rp_n, fl_rp_hv, fl_word_sel, fl_a9_hv;
    int   err_total = 0, n_tests = 0;

    flbp_host #(.PROT_CYCLES(8), .UNPROT_CYCLES(8)) DUT (.clk, .rst,
        .cmd_valid, .cmd_op, .cmd_addr, .cmd_addr_m1, .cmd_wdata, .word_mode,
        .temp_unprot, .cmd_ready, .done, .rdata, .fl_ce_n, .fl_ce_hv,
        .fl_oe_n, .fl_oe_hv, .fl_we_n, .fl_rp_n, .fl_rp_hv, .fl_word_sel,
        .fl_a9_hv, .fl_addr, .dq_i, .dq_o, .dq_oe_n);
    flbp_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (.clk,
        .fl_ce_n, .fl_ce_hv, .fl_oe_n, .fl_oe_hv, .fl_we_n, .fl_rp_n,
        .fl_rp_hv, .fl_word_sel, .fl_a9_hv, .fl_addr, .dq_i, .dev_dq, .dev_oe);

    // Undriven data lines wander, so a stale value can never pass.
    assign dq_i = (~dq_oe_n & dq_o) | (dq_oe_n & dev_oe & dev_dq)
        | (dq_oe_n & ~dev_oe & flt);
    always @(posedge clk) flt <= flt + 16'h1357;
    always #5 clk = ~clk;

    task automatic chk(input string nm, input logic [15:0] s, e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One request, then wait for its completion pulse.
    task automatic op(input logic [2:0] o, input logic [16:0] a,
                      input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        cmd_valid = 1;
        cmd_op = o;
        cmd_addr = a;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 0;
        while (done !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) err_total++;
    endtask

    task automatic t_rw();
        chk("idle ce_n", {15'h0, fl_ce_n}, 16'h1);
        chk("idle dq_oe_n", dq_oe_n, 16'hffff);
        op(3'h1, 17'h00123, 16'ha5c3);
        op(3'h0, 17'h00123, 16'h0000);
        chk("word read", rdata, 16'ha5c3);
        word_mode = 0;
        cmd_addr_m1 = 1;
        op(3'h1, 17'h00200, 16'h005a);
        cmd_addr_m1 = 0;
        op(3'h1, 17'h00200, 16'h0077);
        cmd_addr_m1 = 1;
        op(3'h0, 17'h00200, 16'h0000);
        chk("byte read", rdata, 16'h005a);
        word_mode = 1;
        cmd_addr_m1 = 0;
        $display("test read write done");
    endtask

    task automatic t_sig();
        for (int i = 0; i < 2; i++) begin
            op(3'h2, 17'h1f5bc | 17'(i), 16'h0000);
            chk("signature", rdata, {8'h00, i ? PART : MAKER});
        end
        $display("test signature done");
    endtask

    task automatic t_prot();
        op(3'h1, 17'h03010, 16'h1111);
        op(3'h3, 17'h03000, 16'h0000);
        op(3'h5, 17'h03000, 16'h0000);
        chk("verify protected", rdata, 16'h0001);
        op(3'h5, 17'h04000, 16'h0000);
        chk("verify open", rdata, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            temp_unprot = (i == 1);
            op(3'h1, 17'h03010, 16'h1111 * 16'(i + 2));
            op(3'h0, 17'h03010, 16'h0000);
            chk("guarded data", rdata,
                i ? 16'h3333 : 16'h1111);
        end
        $display("test protect done");
    endtask

    task automatic t_unprot();
        for (int b = 0; b < 32; b++) op(3'h3, {b[4:0], 12'h000}, 16'h0);
        op(3'h4, 17'h00000, 16'h0000);
        for (int b = 0; b < 32; b++) begin
            op(3'h6, {b[4:0], 12'h000}, 16'h0000);
            chk("unprotect verify", rdata, 16'h0000);
        end
        op(3'h7, 17'h00000, 16'h0000);
        chk("ready after reset", {15'h0, cmd_ready}, 16'h1);
        $display("test unprotect done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Whole run takes about eleven hundred cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        t_rw();
        t_sig();
        t_prot();
        t_unprot();
        summarize();
    end
endmodule
